/* core/lmz_pkg.sv */
// package: constants and types for the mode register / calibration command block
package lmz_pkg;

  // ---------------------------------------------------------------
  // apb register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_LAST_MRW = 8'h08;
  localparam logic [7:0] ADDR_ZQ_COUNT = 8'h0C;
  localparam int CTRL_X32_BIT = 0;
  localparam int CTRL_ZQ_ABSENT_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // ---------------------------------------------------------------
  // mode register addresses and codes
  // ---------------------------------------------------------------
  localparam logic [7:0] MR_PATTERN_A = 8'h20;
  localparam logic [7:0] MR_PATTERN_B = 8'h28;
  localparam logic [7:0] MR_ZQ_CAL = 8'h0A;
  localparam logic [7:0] MR_RESET = 8'h3F;
  localparam logic [3:0] PATTERN_A_BITS = 4'hA;
  localparam logic [3:0] PATTERN_B_BITS = 4'h3;
  localparam logic [7:0] ZQ_CODE_INIT = 8'hFF;
  localparam logic [7:0] ZQ_CODE_LONG = 8'hAB;
  localparam logic [7:0] ZQ_CODE_SHORT = 8'h56;
  localparam logic [7:0] ZQ_CODE_RESET = 8'hC3;
  localparam logic [3:0] CMD_MRW = 4'h0;
  localparam logic [3:0] CMD_MRR = 4'h8;
  localparam int BURST_BEATS = 4;
  localparam int DQ_WIDTH = 32;
  localparam logic [31:0] RON_DEFAULT = 32'h0000_0000;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_MRR_CK = 2;
  localparam int T_MRW_CK = 5;
  localparam int RL_CK = 3;
  localparam int T_ZQINIT_NS = 1000;
  localparam int T_ZQCL_NS = 360;
  localparam int T_ZQCS_NS = 90;
  localparam int T_ZQRESET_NS = 50;
  localparam int T_INIT5_NS = 10000;
  localparam int ZQINIT_CK = T_ZQINIT_NS / CLK_PERIOD_NS;
  localparam int ZQCL_CK = T_ZQCL_NS / CLK_PERIOD_NS;
  localparam int ZQCS_CK = T_ZQCS_NS / CLK_PERIOD_NS;
  localparam int ZQRESET_CK = T_ZQRESET_NS / CLK_PERIOD_NS;
  localparam int INIT_CK = T_INIT5_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    ZQ_INIT,
    ZQ_LONG,
    ZQ_SHORT,
    ZQ_RESET
  } lmz_zq_e;

  typedef struct packed {
    logic cs_n;
    logic [9:0] ca_rise;
    logic [9:0] ca_fall;
  } lmz_ca_s;

  typedef struct packed {
    logic [DQ_WIDTH-1:0] dq;
    logic [DQ_WIDTH-1:0] dq_oe_n;
  } lmz_dq_s;

endpackage : lmz_pkg

/* core/lmz_top.sv */
// module: mode register read/write, dq calibration and zq calibration command handling
// Summary of operation
// - read of register 32 returns pattern 1,0,1,0 over four beats
// - read of register 40 returns pattern 0,0,1,1 over four beats
// - pattern on dq 0 and 8, plus 16 and 24 in 32-bit width
// - all other lines of each byte lane copy dq 0 during the burst
// - every mode register read is a four-beat burst, never interrupted
// - write decoded when chip select and command bits 0 to 3 are low
// - address from fall bits 1-0 and rise 9-4; data from fall bits 9-2
// - writes to read-only registers change nothing
// - reads allowed with banks active; writes forbidden while banks active
// - write to address 63 resets and restores every mode register default
// - four calibration commands via register 10, each with its own period
// - calibration reset restores default impedance, then stays busy for its own 5-cycle period
// - with no resistor fitted calibration commands are ignored
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
module lmz_top #(
  parameter int ZQINIT_CYCLES = lmz_pkg::ZQINIT_CK,
  parameter int INIT_CYCLES = lmz_pkg::INIT_CK
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire lmz_pkg::lmz_ca_s i_ca,
  input wire logic i_banks_active,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output lmz_pkg::lmz_dq_s o_dq,
  output logic o_busy,
  output logic [31:0] o_ron_setting
);
  import lmz_pkg::*;

  // ---------------------------------------------------------------
  // command pins: two-flop synchronisers
  // ---------------------------------------------------------------
  lmz_ca_s ca_meta_q;
  lmz_ca_s ca_sync_q;
  logic banks_meta_q;
  logic banks_q;
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      ca_meta_q <= '{cs_n: 1'b1, ca_rise: '0, ca_fall: '0};
      ca_sync_q <= '{cs_n: 1'b1, ca_rise: '0, ca_fall: '0};
      banks_meta_q <= 1'b0;
      banks_q <= 1'b0;
    end else begin
      ca_meta_q <= i_ca;
      ca_sync_q <= ca_meta_q;
      banks_meta_q <= i_banks_active;
      banks_q <= banks_meta_q;
    end
  end

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_MRR,
    ST_MRW,
    ST_ZQ,
    ST_RESETTING
  } lmz_state_e;

  lmz_state_e state_q;
  logic [15:0] wait_q;
  logic [15:0] wait_d;
  logic [2:0] beat_q;
  logic [3:0] pattern_q;
  logic pat_valid_q;
  logic x32_q;
  logic zq_absent_q;
  logic [7:0] last_addr_q;
  logic [7:0] last_data_q;
  logic [15:0] zq_count_q;
  logic [31:0] ron_q;

  wire cmd_sel = !ca_sync_q.cs_n;
  wire idle = (state_q == ST_IDLE);
  wire is_mrw = cmd_sel && (ca_sync_q.ca_rise[3:0] == CMD_MRW);
  wire is_mrr = cmd_sel && (ca_sync_q.ca_rise[3:0] == CMD_MRR);
  wire [7:0] mr_addr = {ca_sync_q.ca_fall[1:0], ca_sync_q.ca_rise[9:4]};
  wire [7:0] mr_data = ca_sync_q.ca_fall[9:2];
  wire mrw_ok = idle && is_mrw && !banks_q;
  wire mrr_ok = idle && is_mrr;
  wire do_reset = mrw_ok && (mr_addr == MR_RESET);
  wire zq_cmd = mrw_ok && (mr_addr == MR_ZQ_CAL) && !zq_absent_q;
  wire zq_valid = (mr_data == ZQ_CODE_INIT) || (mr_data == ZQ_CODE_LONG)
                  || (mr_data == ZQ_CODE_SHORT) || (mr_data == ZQ_CODE_RESET);
  wire do_zq = zq_cmd && zq_valid;
  wire is_cal_mr = (mr_addr == MR_PATTERN_A) || (mr_addr == MR_PATTERN_B);
  wire [3:0] pat_sel = (mr_addr == MR_PATTERN_A) ? PATTERN_A_BITS : PATTERN_B_BITS;

  // zq period lookup per command code
  logic [15:0] zq_period;
  always_comb begin
    zq_period = 16'(ZQRESET_CK);
    if (mr_data == ZQ_CODE_INIT) zq_period = 16'(ZQINIT_CYCLES);
    else if (mr_data == ZQ_CODE_LONG) zq_period = 16'(ZQCL_CK);
    else if (mr_data == ZQ_CODE_SHORT) zq_period = 16'(ZQCS_CK);
  end

  // ---------------------------------------------------------------
  // state machine
  // ---------------------------------------------------------------
  lmz_state_e state_d;
  always_comb begin
    state_d = state_q;
    wait_d = (wait_q != '0) ? wait_q - 16'h0001 : wait_q;
    unique case (state_q)
      ST_IDLE: begin
        if (do_reset) begin
          state_d = ST_RESETTING;
          wait_d = 16'(INIT_CYCLES);
        end else if (do_zq) begin
          state_d = ST_ZQ;
          wait_d = zq_period;
        end else if (mrw_ok) begin
          state_d = ST_MRW;
          wait_d = 16'(T_MRW_CK);
        end else if (mrr_ok) begin
          state_d = ST_MRR;
          wait_d = 16'(RL_CK + BURST_BEATS);
        end
      end
      ST_MRR, ST_MRW, ST_ZQ, ST_RESETTING: begin
        if (wait_q == 16'h0001) state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      state_q <= ST_IDLE;
      wait_q <= '0;
    end else begin
      state_q <= state_d;
      wait_q <= wait_d;
    end
  end

  // ---------------------------------------------------------------
  // read burst: pattern drive on the data lines
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      pattern_q <= '0;
      pat_valid_q <= 1'b0;
    end else if (mrr_ok) begin
      pattern_q <= is_cal_mr ? pat_sel : 4'h0;
      pat_valid_q <= is_cal_mr;
    end
  end

  // burst beats count up once the read latency has passed
  wire in_burst = (state_q == ST_MRR) && (wait_q <= 16'(BURST_BEATS)) && (wait_q != '0);
  wire [1:0] beat_idx = 2'(16'(BURST_BEATS) - wait_q);
  wire beat_bit = pattern_q[3 - beat_idx] && pat_valid_q;
  assign beat_q = {1'b0, beat_idx};

  lmz_dq_s dq_d;
  always_comb begin
    dq_d.dq = {DQ_WIDTH{beat_bit}};
    dq_d.dq_oe_n = '1;
    if (in_burst) dq_d.dq_oe_n = x32_q ? '0 : {{(DQ_WIDTH/2){1'b1}}, {(DQ_WIDTH/2){1'b0}}};
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) o_dq <= '{dq: '0, dq_oe_n: '1};
    else o_dq <= dq_d;
  end

  // ---------------------------------------------------------------
  // mode register state, defaults restored by the reset write
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      last_addr_q <= '0;
      last_data_q <= '0;
      ron_q <= RON_DEFAULT;
      zq_count_q <= '0;
    end else if (do_reset) begin
      last_addr_q <= mr_addr;
      last_data_q <= '0;
      ron_q <= RON_DEFAULT;
    end else if (mrw_ok && !is_cal_mr) begin
      last_addr_q <= mr_addr;
      last_data_q <= mr_data;
      if (do_zq) begin
        zq_count_q <= zq_count_q + 16'h0001;
        ron_q <= (mr_data == ZQ_CODE_RESET) ? RON_DEFAULT : {24'h000000, mr_data};
      end
    end
  end

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  wire apb_wr = i_psel && i_penable && i_pwrite;
  wire apb_rd = i_psel && !i_pwrite;
  wire hit_ctrl = (i_paddr == ADDR_CTRL);
  wire hit_any = hit_ctrl || (i_paddr == ADDR_STATUS) || (i_paddr == ADDR_LAST_MRW)
                 || (i_paddr == ADDR_ZQ_COUNT);
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl) rd_mux = {30'h0, zq_absent_q, x32_q};
    else if (i_paddr == ADDR_STATUS) rd_mux = {28'h0, banks_q, 3'(state_q)};
    else if (i_paddr == ADDR_LAST_MRW) rd_mux = {16'h0, last_addr_q, last_data_q};
    else if (i_paddr == ADDR_ZQ_COUNT) rd_mux = {16'h0, zq_count_q};
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      x32_q <= CTRL_RESET[CTRL_X32_BIT];
      zq_absent_q <= CTRL_RESET[CTRL_ZQ_ABSENT_BIT];
      o_prdata <= '0;
    end else begin
      if (apb_wr && hit_ctrl) begin
        x32_q <= i_pwdata[CTRL_X32_BIT];
        zq_absent_q <= i_pwdata[CTRL_ZQ_ABSENT_BIT];
      end
      if (apb_rd && !i_penable) o_prdata <= rd_mux;
    end
  end

  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !hit_any;
  assign o_busy = !idle;
  assign o_ron_setting = ron_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_mrr_four_beats: assert property (@(posedge i_clock) disable iff (i_reset)
    $rose(in_burst) |-> in_burst [*4] ##1 !in_burst)
    else $error("read burst is not four beats");
  a_pattern_a_bits: assert property (@(posedge i_clock) disable iff (i_reset)
    (mrr_ok && mr_addr == MR_PATTERN_A) |=> pattern_q == 4'hA)
    else $error("pattern a wrong");
  a_pattern_b_bits: assert property (@(posedge i_clock) disable iff (i_reset)
    (mrr_ok && mr_addr == MR_PATTERN_B) |=> pattern_q == 4'h3)
    else $error("pattern b wrong");
  a_lane_copy: assert property (@(posedge i_clock) disable iff (i_reset)
    (o_dq.dq == '0) || (o_dq.dq == '1))
    else $error("lanes differ from dq0");
  a_lane_enable: assert property (@(posedge i_clock) disable iff (i_reset)
    (!x32_q && !o_dq.dq_oe_n[0]) |-> o_dq.dq_oe_n[DQ_WIDTH-1])
    else $error("upper half driven in 16-bit width");
  a_mrw_blocked: assert property (@(posedge i_clock) disable iff (i_reset)
    (idle && is_mrw && banks_q) |=> idle)
    else $error("write accepted with banks active");
  a_reset_restores: assert property (@(posedge i_clock) disable iff (i_reset)
    do_reset |=> (ron_q == RON_DEFAULT) && (state_q == ST_RESETTING))
    else $error("reset write did not restore defaults");
  a_zq_ignored: assert property (@(posedge i_clock) disable iff (i_reset)
    (zq_absent_q && idle && is_mrw && mr_addr == MR_ZQ_CAL) |=> state_q != ST_ZQ)
    else $error("zq command taken without resistor");
  a_mrw_decode: assert property (@(posedge i_clock) disable iff (i_reset)
    (idle && cmd_sel && ca_sync_q.ca_rise[3:0] != CMD_MRW && !is_mrr) |=> idle)
    else $error("non write command started a write");
  a_mrr_period: assert property (@(posedge i_clock) disable iff (i_reset)
    mrr_ok |=> (state_q == ST_MRR) [*7] ##1 idle)
    else $error("read period is not latency plus four beats");
  a_mrw_period: assert property (@(posedge i_clock) disable iff (i_reset)
    (mrw_ok && !do_reset && !do_zq) |=> (state_q == ST_MRW) [*5] ##1 idle)
    else $error("write period length wrong");
  a_zq_short_len: assert property (@(posedge i_clock) disable iff (i_reset)
    (do_zq && mr_data == ZQ_CODE_SHORT) |-> ##9 (state_q == ST_ZQ) ##1 idle)
    else $error("short calibration period length wrong");
  a_zq_count_step: assert property (@(posedge i_clock) disable iff (i_reset)
    do_zq |=> zq_count_q == $past(zq_count_q) + 16'h0001)
    else $error("calibration command not counted");
  a_dq_quiet: assert property (@(posedge i_clock) disable iff (i_reset)
    !in_burst |=> o_dq.dq_oe_n == '1)
    else $error("data lines driven outside a read burst");
  c_pattern_read: cover property (@(posedge i_clock) disable iff (i_reset)
    mrr_ok && is_cal_mr);
  c_zq_long: cover property (@(posedge i_clock) disable iff (i_reset)
    do_zq && mr_data == ZQ_CODE_LONG);
  c_reset_write: cover property (@(posedge i_clock) disable iff (i_reset) do_reset);
  c_pattern_b_x32: cover property (@(posedge i_clock) disable iff (i_reset)
    mrr_ok && mr_addr == MR_PATTERN_B && x32_q);
  c_zq_ignored: cover property (@(posedge i_clock) disable iff (i_reset)
    zq_absent_q && mrw_ok && mr_addr == MR_ZQ_CAL);

endmodule : lmz_top

/* testbench/lmz_ctrl_model.sv */
// memory controller model: drives the command pins and captures read bursts
`timescale 1ns/100ps
module lmz_ctrl_model (
  input wire logic i_clock,
  input wire logic i_busy,
  input wire lmz_pkg::lmz_dq_s i_dq,
  output lmz_pkg::lmz_ca_s o_ca,
  output logic o_banks_active
);
  import lmz_pkg::*;
  lmz_dq_s beats [4];
  int nbeats;
  int nbusy;
  initial begin
    o_ca = '{1'b1, 10'h155, 10'h2AA};
    o_banks_active = 1'b0;
  end
  // banks are opened only around a write that must be refused and a read that must still run
  task automatic set_banks(input logic v);
    @(posedge i_clock);
    o_banks_active <= v;
  endtask : set_banks
  // one command cycle, then nops with toggling lines until idle again
  task automatic send(input logic rd, input logic [7:0] adr, input logic [7:0] dat);
    int i;
    @(posedge i_clock);
    o_ca <= '{1'b0, {adr[5:0], rd ? CMD_MRR : CMD_MRW}, {dat, adr[7:6]}};
    nbeats = 0;
    nbusy = 0;
    for (i = 0; i < 80; i++) begin
      @(posedge i_clock);
      o_ca <= '{1'b1, ~o_ca.ca_rise, ~o_ca.ca_fall};
      @(negedge i_clock);
      if (i_busy === 1'b1) nbusy++;
      if (i_dq.dq_oe_n[0] === 1'b0) begin
        if (nbeats < 4) beats[nbeats] = i_dq;
        nbeats++;
      end
      if (i > 8 && i_busy !== 1'b1) break;
    end
  endtask : send
endmodule : lmz_ctrl_model

/* testbench/testbench.sv */
// self-checking bench for the mode register and calibration block
`timescale 1ns/100ps
module testbench;
  import lmz_pkg::*;
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0;
  logic [31:0] o_prdata, o_ron_setting, rd, cnt, ron;
  logic o_pready, o_pslverr, o_busy, err;
  lmz_ca_s i_ca;
  logic i_banks_active;
  lmz_dq_s o_dq;
  logic [7:0] a, d;
  logic [7:0] zq_code [5] = '{ZQ_CODE_INIT, ZQ_CODE_LONG, ZQ_CODE_SHORT, ZQ_CODE_RESET, 8'h11};
  int zq_min [5] = '{18, ZQCL_CK - 2, ZQCS_CK - 2, 0, 0};
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  int k;
  always #5 i_clock = ~i_clock;
  lmz_top #(.ZQINIT_CYCLES(20), .INIT_CYCLES(20)) lmz_top_i (
    .i_clock(i_clock), .i_reset(i_reset), .i_ca(i_ca), .i_banks_active(i_banks_active),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_dq(o_dq), .o_busy(o_busy), .o_ron_setting(o_ron_setting));
  lmz_ctrl_model lmz_ctrl_model_i (.i_clock(i_clock), .i_busy(o_busy), .i_dq(o_dq),
    .o_ca(i_ca), .o_banks_active(i_banks_active));
  task automatic results();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  task automatic chk(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      failures++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge i_clock);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= ad;
    i_pwdata <= wd;
    @(posedge i_clock);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clock);
    end while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb
  task automatic burst(input logic [7:0] mr, input logic x32);
    int b;
    logic v;
    lmz_dq_s q;
    lmz_ctrl_model_i.send(1'b1, mr, 8'h00);
    chk(lmz_ctrl_model_i.nbeats == 4, "burst length");
    for (b = 0; b < 4; b++) begin
      v = (mr == MR_PATTERN_A) ? (b % 2 == 0) : (b >= 2);
      q = lmz_ctrl_model_i.beats[b];
      if (x32) chk(q === {{32{v}}, 32'h0}, "x32 beat");
      else chk({q.dq[15:0], q.dq_oe_n[15:0]} === {{16{v}}, 16'h0}, "x16 beat");
    end
  endtask : burst
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      $display("mismatch at %0t: run timed out", $time);
      results();
    end
  end
  initial begin
    void'($urandom(11));
    repeat (2) @(posedge i_clock);
    chk(o_dq.dq_oe_n === '1 && o_busy === 1'b0, "reset outputs");
    i_reset <= 1'b0;
    apb(1'b0, 8'h10, 32'h0);
    chk(err === 1'b1 && rd === 32'h0, "unmapped read");
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd[1:0] === CTRL_RESET && err === 1'b0, "ctrl reset");
    lmz_ctrl_model_i.send(1'b0, MR_ZQ_CAL, ZQ_CODE_INIT);
    lmz_ctrl_model_i.send(1'b0, MR_PATTERN_A, 8'h5A);
    apb(1'b0, ADDR_LAST_MRW, 32'h0);
    chk(rd[15:0] === {MR_ZQ_CAL, ZQ_CODE_INIT}, "read-only write kept out");
    for (k = 0; k < 2; k++) begin
      apb(1'b1, ADDR_CTRL, {$urandom} & 32'hFFFF_FFFC | k);
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk(rd[1:0] === k[1:0], "ctrl readback");
      burst(MR_PATTERN_A, k[0]);
      burst(MR_PATTERN_B, k[0]);
    end
    for (k = 0; k < 3; k++) begin
      a = 8'h40 | 8'($urandom_range(0, 191));
      d = 8'($urandom);
      lmz_ctrl_model_i.send(1'b0, a, d);
      apb(1'b0, ADDR_LAST_MRW, 32'h0);
      chk(rd[15:0] === {a, d}, "write address and data");
    end
    lmz_ctrl_model_i.set_banks(1'b1);
    lmz_ctrl_model_i.send(1'b0, 8'h05, ~d);
    chk(lmz_ctrl_model_i.nbusy == 0, "write with banks active");
    lmz_ctrl_model_i.send(1'b1, 8'h05, 8'h00);
    chk(lmz_ctrl_model_i.nbeats == 4, "read with banks active");
    lmz_ctrl_model_i.set_banks(1'b0);
    apb(1'b0, ADDR_LAST_MRW, 32'h0);
    chk(rd[15:0] === {a, d}, "refused write kept out");
    for (k = 0; k < 5; k++) begin
      apb(1'b0, ADDR_ZQ_COUNT, 32'h0);
      cnt = rd;
      lmz_ctrl_model_i.send(1'b0, MR_ZQ_CAL, zq_code[k]);
      apb(1'b0, ADDR_ZQ_COUNT, 32'h0);
      chk(rd === cnt + ((k < 4) ? 32'h1 : 32'h0), "zq command count");
      chk(lmz_ctrl_model_i.nbusy >= zq_min[k], "zq period");
    end
    chk(o_ron_setting === RON_DEFAULT, "zq reset default");
    apb(1'b1, ADDR_CTRL, 32'h2);
    ron = o_ron_setting;
    lmz_ctrl_model_i.send(1'b0, MR_ZQ_CAL, ZQ_CODE_LONG);
    apb(1'b0, ADDR_ZQ_COUNT, 32'h0);
    chk(rd === cnt && lmz_ctrl_model_i.nbusy == T_MRW_CK, "zq absent");
    chk(o_ron_setting === ron, "zq absent keeps setting");
    lmz_ctrl_model_i.send(1'b0, MR_RESET, 8'h00);
    chk(lmz_ctrl_model_i.nbusy >= 18 && o_busy === 1'b0, "reset period");
    apb(1'b0, ADDR_LAST_MRW, 32'h0);
    chk(rd[15:0] === {MR_RESET, 8'h00}, "reset write restores defaults");
    burst(MR_PATTERN_A, 1'b0);
    results();
  end
endmodule : testbench
